// *** rtl/sleep_regulator_defines.vh ***
// Register map, field positions and reset values for the sleep entry block.
// Assumes a 32-bit APB slave; each register takes one aligned word.
`ifndef SLEEP_REGULATOR_DEFINES_VH
`define SLEEP_REGULATOR_DEFINES_VH
`define OFF_REG_SLEEP_CTRL   12'h000
`define OFF_OSC_STATUS       12'h004
`define OFF_CLK_SWITCH       12'h008
`define BIT_RSVD_ONE         0
`define BIT_POWER_MODE       1
`define REG_SLEEP_CTRL_RESET 8'h01
`define OSC_STAT_PLL_READY   0
`define OSC_STAT_HF_READY    1
`define OSC_STAT_SWITCH_BUSY 2
`define CLK_SEL_PLL          0
`define SWITCH_WAIT_CYCLES   8'h10
`endif

// *** rtl/sleep_entry_regulator_mode.v ***
// APB register block for sleep entry: oscillator ready flags and regulator sleep mode.
// Assumes APB master on CORE_CLK_I; an internal wait counter times the clock switch, with no completion input.
//
// Contract
// - Status register shows per-oscillator ready flags
// - PLL ready sets once 32 MHz active
// - PLL ready clears once switch off completes
// - Mode bit one: low-power regulator in sleep
// - Mode bit zero: normal-power regulator in sleep
// - Bit zero reads one; software writes one
// - Upper six bits ignore writes, read zero
//
// Our own choices: the placing of the registers and the APB slave port.
`default_nettype none
`include "sleep_regulator_defines.vh"

module sleep_entry_regulator_mode (
  input  wire        CORE_CLK_I,
  input  wire        RST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        SLEEP_I,
  input  wire        HF_READY_I,
  output reg         PLL_SELECT_O,
  output reg         REG_LOW_POWER_O,
  output reg         IN_SLEEP_O
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ON   = 3'b010;
  localparam ST_OFF  = 3'b100;

  // Reset image of the control register; bit zero is the reserved one
  localparam [7:0] CTRL_RESET = `REG_SLEEP_CTRL_RESET;

  reg         power_mode_ff;
  reg         pll_ready_ff;
  reg         pll_req_ff;
  reg  [2:0]  state_ff;
  reg  [7:0]  wait_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  nxt_wait;
  reg         nxt_pll_ready;
  reg  [31:0] rd_data;
  reg         sel_ctrl;
  reg         sel_stat;
  reg         sel_switch;
  wire [31:0] ctrl_image;
  wire [31:0] stat_image;
  wire [31:0] switch_image;
  wire        switch_busy;
  wire        addr_ok;
  wire        access;
  wire        first_access;
  wire        completing;
  wire        wr_done;
  genvar      gi;

  assign access       = PSEL_I & PENABLE_I;
  // First access cycle starts the single wait state
  assign first_access = access & ~PREADY_O;
  // Completion edge: the master samples PREADY_O high here
  assign completing   = access & PREADY_O;
  assign wr_done      = completing & PWRITE_I;

  // Address decode; anything else answers with an error
  always @* begin
    sel_ctrl   = 1'b0;
    sel_stat   = 1'b0;
    sel_switch = 1'b0;
    case (PADDR_I)
      `OFF_REG_SLEEP_CTRL: begin
        sel_ctrl = 1'b1;
      end
      `OFF_OSC_STATUS: begin
        sel_stat = 1'b1;
      end
      `OFF_CLK_SWITCH: begin
        sel_switch = 1'b1;
      end
      default: begin
        sel_ctrl = 1'b0;
      end
    endcase
  end

  assign addr_ok = sel_ctrl | sel_stat | sel_switch;

  // Control register image bit by bit; only bits 1:0 exist
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_ctrl_bit
      if (gi == `BIT_RSVD_ONE) begin : g_rsvd
        assign ctrl_image[gi] = 1'b1;
      end else if (gi == `BIT_POWER_MODE) begin : g_mode
        assign ctrl_image[gi] = power_mode_ff;
      end else begin : g_unimpl
        assign ctrl_image[gi] = 1'b0;
      end
    end
  endgenerate

  // Busy also covers the cycle before the sequencer leaves idle
  assign switch_busy = ~state_ff[0] | (pll_req_ff ^ pll_ready_ff);

  assign stat_image[`OSC_STAT_PLL_READY]   = pll_ready_ff;
  assign stat_image[`OSC_STAT_HF_READY]    = HF_READY_I;
  assign stat_image[`OSC_STAT_SWITCH_BUSY] = switch_busy;
  assign stat_image[31:3]                  = 29'h0;

  assign switch_image[`CLK_SEL_PLL] = pll_req_ff;
  assign switch_image[31:1]         = 31'h0;

  // Read mux; unmapped addresses read as zero beside the error
  always @* begin
    rd_data = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_data = ctrl_image;
    end else if (sel_stat) begin
      rd_data = stat_image;
    end else if (sel_switch) begin
      rd_data = switch_image;
    end
  end

  // Switch sequencer: ready flag only moves once the new clock is in effect
  always @* begin
    nxt_state     = state_ff;
    nxt_wait      = wait_ff;
    nxt_pll_ready = pll_ready_ff;
    case (state_ff)
      ST_IDLE: begin
        if (pll_req_ff != pll_ready_ff) begin
          nxt_wait  = `SWITCH_WAIT_CYCLES;
          nxt_state = pll_req_ff ? ST_ON : ST_OFF;
        end
      end
      ST_ON: begin
        if (wait_ff == 8'h00) begin
          nxt_pll_ready = 1'b1;
          nxt_state     = ST_IDLE;
        end else begin
          nxt_wait = wait_ff - 8'h01;
        end
      end
      ST_OFF: begin
        if (wait_ff == 8'h00) begin
          nxt_pll_ready = 1'b0;
          nxt_state     = ST_IDLE;
        end else begin
          nxt_wait = wait_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Switch sequencer state; the pin mirrors the flag in the same cycle
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_ff     <= ST_IDLE;
      wait_ff      <= 8'h00;
      pll_ready_ff <= 1'b0;
      PLL_SELECT_O <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      wait_ff      <= nxt_wait;
      pll_ready_ff <= nxt_pll_ready;
      PLL_SELECT_O <= nxt_pll_ready;
    end
  end

  // Writes land on the completion edge only
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      power_mode_ff <= CTRL_RESET[`BIT_POWER_MODE];
      pll_req_ff    <= 1'b0;
    end else begin
      if (wr_done & sel_ctrl) begin
        // Bit zero is held at one regardless of what software writes
        power_mode_ff <= PWDATA_I[`BIT_POWER_MODE];
      end
      if (wr_done & sel_switch) begin
        pll_req_ff <= PWDATA_I[`CLK_SEL_PLL];
      end
    end
  end

  // One wait state per transfer: costs a cycle, keeps outputs registered
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= first_access;
      PSLVERR_O <= first_access & ~addr_ok;
      if (first_access & ~PWRITE_I) begin
        PRDATA_O <= rd_data;
      end else begin
        PRDATA_O <= 32'h0000_0000;
      end
    end
  end

  // Sleep honoured regardless; losing the clock mid-switch is software's hazard
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      IN_SLEEP_O      <= 1'b0;
      REG_LOW_POWER_O <= 1'b0;
    end else begin
      IN_SLEEP_O      <= SLEEP_I;
      // Low-power regulator only while asleep; slower wake-up in exchange
      REG_LOW_POWER_O <= SLEEP_I & power_mode_ff;
    end
  end

endmodule // sleep_entry_regulator_mode
`default_nettype wire

// *** test/sleep_entry_regulator_mode_sva.sv ***
// Port checker for the sleep entry block.
// Assumes one clock, APB with one wait state, stable status inputs.
`default_nettype none
module sleep_entry_sva (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        SLEEP_I,
  input wire logic        HF_READY_I,
  input wire logic        PLL_SELECT_O,
  input wire logic        REG_LOW_POWER_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire logic ok = PREADY_O & ~PSLVERR_O;
  wire logic rc = ok & ~PWRITE_I & (PADDR_I == 12'h000);
  wire logic rs = ok & ~PWRITE_I & (PADDR_I == 12'h004);
  wire logic wc = ok & PWRITE_I & (PADDR_I == 12'h000);
  wire logic ws = ok & PWRITE_I & (PADDR_I == 12'h008);
  logic mode_q;
  // Shadow of the power mode bit, taken from completed control writes
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      mode_q <= 1'b0;
    end else if (wc) begin
      mode_q <= PWDATA_I[1];
    end
  end
  AST_RSVD_ONE: assert property (rc |-> PRDATA_O[0]) else $error("bit0 low");
  AST_UPPER_ZERO: assert property (
    rc |-> PRDATA_O[31:2] == 30'h0) else $error("upper set");
  AST_STAT_FLAGS: assert property (
    rs && $stable(PLL_SELECT_O) && $stable(HF_READY_I)
    |-> PRDATA_O[1:0] == {HF_READY_I, PLL_SELECT_O}) else $error("status flags");
  AST_PLL_SET: assert property (
    ws && PWDATA_I[0] |-> ##[1:40] PLL_SELECT_O) else $error("pll not ready");
  AST_PLL_CLR: assert property (
    ws && !PWDATA_I[0] |-> ##[1:40] !PLL_SELECT_O) else $error("pll not cleared");
  AST_LOW_PWR: assert property (
    SLEEP_I && mode_q |=> REG_LOW_POWER_O) else $error("low power missing");
  AST_NORM_PWR: assert property (
    SLEEP_I && !mode_q |=> !REG_LOW_POWER_O) else $error("normal power missing");
  AST_LP_AWAKE: assert property (
    REG_LOW_POWER_O |-> $past(SLEEP_I)) else $error("lp awake");
  C_CTRL: cover property (rc);
  C_ERR: cover property (PSLVERR_O);
  C_LP: cover property (REG_LOW_POWER_O);
  C_PLL: cover property (ws && PWDATA_I[0]);
endmodule // sleep_entry_sva
bind sleep_entry_regulator_mode sleep_entry_sva i_chk (
  .CORE_CLK_I      (CORE_CLK_I),
  .RST_I           (RST_I),
  .PWRITE_I        (PWRITE_I),
  .PADDR_I         (PADDR_I),
  .PWDATA_I        (PWDATA_I),
  .PRDATA_O        (PRDATA_O),
  .PREADY_O        (PREADY_O),
  .PSLVERR_O       (PSLVERR_O),
  .SLEEP_I         (SLEEP_I),
  .HF_READY_I      (HF_READY_I),
  .PLL_SELECT_O    (PLL_SELECT_O),
  .REG_LOW_POWER_O (REG_LOW_POWER_O)
);
`default_nettype wire

// *** test/sleep_entry_regulator_mode_tb_top.sv ***
// Self-checking bench for the sleep entry block.
// Drives APB and the sleep and oscillator inputs directly.
`default_nettype none
module sleep_entry_regulator_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, slp = 0, hf = 1, e;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, q;
  wire logic [31:0] rd;
  wire logic rdy, err, pll, lp, ins;
  int mismatches, tests_run;
  always #2 clk = ~clk;
  sleep_entry_regulator_mode i_dut (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(sel),
    .PENABLE_I(en), .PWRITE_I(wr), .PADDR_I(adr), .PWDATA_I(wd), .PRDATA_O(rd),
    .PREADY_O(rdy), .PSLVERR_O(err), .SLEEP_I(slp), .HF_READY_I(hf),
    .PLL_SELECT_O(pll), .REG_LOW_POWER_O(lp), .IN_SLEEP_O(ins));
  task chk(input string s, input logic [31:0] g, x);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  // Idle edge after release, so no signal is driven twice in one step
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    sel <= 1'b1;
    wr  <= w;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    en <= 1'b1;
    // Ends once rdy is seen high; only the watchdog bounds this wait
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = rd;
    e = err;
    sel <= 1'b0;
    en  <= 1'b0;
    @(posedge clk);
  endtask
  task t_ctrl;
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", q, 32'h1);
    chk("ctrl no error", {31'h0, e}, 32'h0);
    bus(1'b1, 12'h000, 32'hFFFF_FFFF);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl ones", q, 32'h3);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl zero", q, 32'h1);
    bus(1'b1, 12'h000, 32'h1);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl low", q, 32'h1);
    bus(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("ctrl test done");
  endtask
  task t_pll(input logic v);
    int n;
    n = 0;
    bus(1'b1, 12'h008, {31'h0, v});
    // Poll before sleep; the flag moves only once the switch is over
    do begin
      bus(1'b0, 12'h004, 32'h0);
      n++;
    end while (q[0] !== v && n < 20);
    chk("pll flag", {31'h0, q[0]}, {31'h0, v});
    chk("pll pin", {31'h0, pll}, {31'h0, v});
    chk("hf flag", {31'h0, q[1]}, {31'h0, hf});
    $display("pll test done");
  endtask
  task t_sleep(input logic m);
    bus(1'b1, 12'h000, {30'h0, m, 1'b1});
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    chk("low power", {31'h0, lp}, {31'h0, m});
    chk("in sleep", {31'h0, ins}, 32'h1);
    slp <= 1'b0;
    repeat (2) @(posedge clk);
    chk("awake", {31'h0, lp}, 32'h0);
    chk("not in sleep", {31'h0, ins}, 32'h0);
    $display("sleep test done");
  endtask
  task t_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pll pin in reset", {31'h0, pll}, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl after reset", q, 32'h1);
    bus(1'b0, 12'h004, 32'h0);
    chk("pll flag after reset", {31'h0, q[0]}, 32'h0);
    $display("reset test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_ctrl;
    t_pll(1'b1);
    hf <= 1'b0;
    t_pll(1'b0);
    t_pll(1'b1);
    t_sleep(1'b1);
    t_reset;
    t_sleep(1'b0);
    complete_run;
  end
  // Run needs well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end
endmodule // sleep_entry_regulator_mode_tb_top
`default_nettype wire
